// ---- hdl/ldr_core.sv ----
//Contract
//- display bytes written bit by bit on arrival; commands wait for ack
//- static mode: eight bits into row 0 of eight words
//- two-backplane: bit pairs into rows 0,1 of four words
//- three-backplane: triples into rows 0-2 of three words
//- four-backplane: quadruples into rows 0-3 of two words
//- pointer loaded by command; bytes start at current pointer
//- pointer advances 8, 4, 3 or 2 per byte by mode
//- RAM written only when subaddress counter equals strapped subaddress
//- subaddress counter loaded by chip-choice command
//- on mismatch write suppressed, pointer still advances
//- subaddress counter increments when pointer passes last word
//- overflow inside a byte continues at word 0 of next device
//- shown row per phase: 0..3, 0..2, 0..1, or 0 by mode
//- static and two-backplane: row-group choice shows rows 2/3 instead of 0/1
//- static and two-backplane: input bank steers writes to rows 2/3, independent of display
//- whole-display blink off or f_clk divided by 768, 1536, 3072
//- static and two-backplane: swap banks at blink rate if chosen
//- display blanked while display-enable bit is 0
//- acknowledge driven only on its own pin; master may ignore it
//- drive-mode field: 01 static, 10 two, 11 three, 00 four
//- control byte bit 7 more-control flag, bit 6 command/data
`timescale 1ns/1ps
`include "ldr_params.svh"
module ldr_core
   import ldr_pkg::*;
#(
   parameter int FCLK_DIV = `LDR_FCLK_DIV,
   parameter int WORDS    = `LDR_RAM_WORDS
) (
   // clock and reset
   input  wire logic              core_clk,
   input  wire logic              resetn,
   // byte stream from the serial front end
   input  wire logic              in_valid,
   input  wire logic [7:0]        in_byte,
   input  wire logic              in_first,
   output logic                   in_ready,
   // acknowledge timing from the front end
   input  wire logic              ack_done,
   input  wire logic              ack_slot,
   // acknowledge pin, open drain
   output logic                   ack_output_pin,
   output logic                   ack_oe_n_r,
   // hardware subaddress straps
   input  wire logic              hw_subaddr_bit0,
   input  wire logic              hw_subaddr_bit1,
   input  wire logic              hw_subaddr_bit2,
   // towards the LCD output stages
   output logic [WORDS-1:0]       seg_data_r,
   output logic [1:0]             bp_phase_r,
   output logic                   blank_r,
   output logic                   bias_half_r,
   output ldr_pkg::ldr_mode_t     drive_mode_r
);
   import ldr_pkg::*;

   localparam int DIV_W = $clog2(FCLK_DIV + 1);

   // rows used per word in each drive mode
   function automatic logic [2:0] rows_of(input ldr_mode_t m);
      case (m)
         LDR_MODE_STAT: rows_of = 3'h1;
         LDR_MODE_DUO:  rows_of = 3'h2;
         LDR_MODE_TRI:  rows_of = 3'h3;
         default:       rows_of = 3'h4;
      endcase
   endfunction

   // f_clk ticks per backplane phase, a frame being fixed in ticks
   function automatic logic [4:0] phase_len(input ldr_mode_t m);
      phase_len = 5'(`LDR_FRAME_TICKS / int'(rows_of(m)));
   endfunction

   function automatic logic has_alt(input ldr_mode_t m);
      has_alt = (m == LDR_MODE_STAT) || (m == LDR_MODE_DUO);
   endfunction

   // buffer between front end and parser
   logic       b_valid;
   logic [8:0] b_data;
   logic       b_ready;

   ldr_buf2 #(.W(9)) u_buf (
      .core_clk  (core_clk),
      .resetn    (resetn),
      .in_valid  (in_valid),
      .in_data   ({in_first, in_byte}),
      .in_ready  (in_ready),
      .out_valid (b_valid),
      .out_data  (b_data),
      .out_ready (b_ready)
   );

   logic [3:0] ram [WORDS];

   // parser and configuration state
   ldr_state_t st_r;
   logic       more_r;
   logic       rs_data_r;
   logic       ack_seen_r;
   logic       disp_en_r;
   logic       in_bank_r;
   logic       out_bank_r;
   logic [1:0] blink_sel_r;
   logic       blink_swap_r;
   logic [`LDR_PTR_W-1:0] ptr_r;
   logic [2:0] sub_r;
   logic       ack_ok_r;

   // bit-serial writer
   logic [7:0] wr_sh_r;
   logic [2:0] wr_bit_r;
   logic [1:0] wr_row_r;

   // display timing
   logic [DIV_W-1:0] fdiv_r;
   logic             f_tick_r;
   logic [4:0]       ph_cnt_r;
   logic [11:0]      blink_cnt_r;
   logic             blink_r;

   logic [2:0] hw_sub;
   logic       sub_match;
   logic       is_first;
   logic [7:0] hb;
   logic       take_ctrl;
   logic       take_data;
   logic       take_cmd;
   logic       wr_busy;
   logic       wr_last;
   logic       row_wrap;
   logic       step_word;
   logic [1:0] wr_base;
   logic [1:0] wr_row_abs;
   logic [2:0] nrows;
   logic [11:0] blink_half;
   logic [1:0] show_row;
   logic       swap_now;
   logic [WORDS-1:0] seg_w;

   assign hw_sub    = {hw_subaddr_bit2, hw_subaddr_bit1, hw_subaddr_bit0};
   assign sub_match = (sub_r == hw_sub);
   assign is_first  = b_data[8];
   assign hb        = b_data[7:0];
   assign wr_busy   = (st_r == LDR_ST_WRITE);
   assign nrows     = rows_of(drive_mode_r);

   // a flagged first byte is always a control byte
   assign take_ctrl = b_valid & !wr_busy & (is_first | st_r == LDR_ST_CTRL);
   // data does not wait for the acknowledge, commands do
   assign take_data = b_valid & !wr_busy & !is_first
                      & (st_r == LDR_ST_BODY) & rs_data_r;
   assign take_cmd  = b_valid & !wr_busy & !is_first
                      & (st_r == LDR_ST_BODY) & !rs_data_r
                      & ack_seen_r;
   assign b_ready   = take_ctrl | take_data | take_cmd;

   // command acknowledge latch: set by the front end, cleared on push
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ack_seen_r <= 1'b0;
      end else if (ack_done) begin
         ack_seen_r <= 1'b1;
      end else if (in_valid & in_ready) begin
         ack_seen_r <= 1'b0;
      end
   end

   // parser state and control byte fields
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         st_r      <= LDR_ST_CTRL;
         more_r    <= 1'b0;
         rs_data_r <= 1'b0;
      end else if (take_ctrl) begin
         more_r    <= hb[`LDR_CTRL_MORE_BIT];
         rs_data_r <= hb[`LDR_CTRL_RS_BIT];
         st_r      <= LDR_ST_BODY;
      end else if (take_data) begin
         st_r <= LDR_ST_WRITE;
      end else if (take_cmd) begin
         st_r <= more_r ? LDR_ST_CTRL : LDR_ST_BODY;
      end else if (wr_busy & wr_last) begin
         st_r <= more_r ? LDR_ST_CTRL : LDR_ST_BODY;
      end
   end

   // command decode, applied once the byte is acknowledged
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         disp_en_r    <= 1'b0;
         bias_half_r  <= 1'b0;
         drive_mode_r <= ldr_mode_t'(`LDR_RST_MODE);
         in_bank_r    <= 1'b0;
         out_bank_r   <= 1'b0;
         blink_sel_r  <= `LDR_RST_BLINK;
         blink_swap_r <= 1'b0;
      end else if (take_cmd) begin
         if ((hb & `LDR_OP_MODE_MASK) == `LDR_OP_MODE) begin
            disp_en_r    <= hb[`LDR_MODE_EN_BIT];
            bias_half_r  <= hb[`LDR_MODE_BIAS_BIT];
            drive_mode_r <= ldr_mode_t'(hb[1:0]);
         end else if ((hb & `LDR_OP_BANK_MASK) == `LDR_OP_BANK) begin
            in_bank_r  <= hb[`LDR_BANK_IN_BIT];
            out_bank_r <= hb[`LDR_BANK_OUT_BIT];
         end else if ((hb & `LDR_OP_BLINK_MASK) == `LDR_OP_BLINK) begin
            blink_sel_r  <= hb[1:0];
            blink_swap_r <= hb[`LDR_BLINK_SWAP_BIT];
         end
      end
   end

   // writer stepping: one bit per cycle, MSB first
   assign wr_last   = (wr_bit_r == 3'h7);
   assign row_wrap  = ({1'b0, wr_row_r} + 3'h1) == nrows;
   // a partly filled word still counts as used at byte end
   assign step_word = row_wrap | (wr_last & (wr_row_r != 2'h0));
   assign wr_base   = (in_bank_r & has_alt(drive_mode_r))
                      ? `LDR_ALT_ROW : 2'h0;
   assign wr_row_abs = wr_base + wr_row_r;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         wr_sh_r  <= 8'h00;
         wr_bit_r <= 3'h0;
         wr_row_r <= 2'h0;
      end else if (take_data) begin
         wr_sh_r  <= hb;
         wr_bit_r <= 3'h0;
         wr_row_r <= 2'h0;
      end else if (wr_busy) begin
         wr_sh_r  <= {wr_sh_r[6:0], 1'b0};
         wr_bit_r <= wr_bit_r + 3'h1;
         wr_row_r <= row_wrap ? 2'h0 : wr_row_r + 2'h1;
      end
   end

   // pointer and subaddress counter
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ptr_r <= '0;
         sub_r <= 3'h0;
      end else if (take_cmd & !hb[`LDR_OP_PTR_BIT]) begin
         ptr_r <= hb[`LDR_PTR_W-1:0];
      end else if (take_cmd
                   & ((hb & `LDR_OP_DEV_MASK) == `LDR_OP_DEV)) begin
         sub_r <= hb[2:0];
      end else if (wr_busy & step_word) begin
         // advance whether or not the bit was stored
         if (ptr_r >= `LDR_LAST_WORD) begin
            ptr_r <= '0;
            sub_r <= sub_r + 3'h1;
         end else begin
            ptr_r <= ptr_r + 7'h01;
         end
      end
   end

   // RAM bit write, gated by the subaddress match
   always_ff @(posedge core_clk) begin
      if (wr_busy & sub_match & (ptr_r <= `LDR_LAST_WORD)) begin
         ram[ptr_r][wr_row_abs] <= wr_sh_r[7];
      end
   end

   // acknowledge pin: data bytes acked only by the matching device
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ack_ok_r <= 1'b0;
      end else if (take_ctrl | take_cmd) begin
         ack_ok_r <= 1'b1;
      end else if (take_data) begin
         ack_ok_r <= sub_match;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ack_output_pin <= 1'b0;
         ack_oe_n_r     <= 1'b1;
      end else begin
         ack_output_pin <= 1'b0;
         ack_oe_n_r     <= ~(ack_slot & ack_ok_r);
      end
   end

   // logic clock enable from the core clock
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         fdiv_r   <= '0;
         f_tick_r <= 1'b0;
      end else if (fdiv_r == DIV_W'(FCLK_DIV - 1)) begin
         fdiv_r   <= '0;
         f_tick_r <= 1'b1;
      end else begin
         fdiv_r   <= fdiv_r + DIV_W'(1);
         f_tick_r <= 1'b0;
      end
   end

   // multiplex phase sequencing
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ph_cnt_r   <= 5'h00;
         bp_phase_r <= 2'h0;
      end else if (f_tick_r) begin
         if (ph_cnt_r >= phase_len(drive_mode_r) - 5'h01) begin
            ph_cnt_r <= 5'h00;
            if ({1'b0, bp_phase_r} + 3'h1 >= nrows) begin
               bp_phase_r <= 2'h0;
            end else begin
               bp_phase_r <= bp_phase_r + 2'h1;
            end
         end else begin
            ph_cnt_r <= ph_cnt_r + 5'h01;
         end
      end
   end

   // blink divider: half of the ratio per on or off interval
   always_comb begin
      case (blink_sel_r)
         2'h1:    blink_half = 12'(`LDR_BLINK_RATIO1 / 2);
         2'h2:    blink_half = 12'(`LDR_BLINK_RATIO2 / 2);
         2'h3:    blink_half = 12'(`LDR_BLINK_RATIO3 / 2);
         default: blink_half = 12'h000;
      endcase
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         blink_cnt_r <= 12'h000;
         blink_r     <= 1'b0;
      end else if (blink_sel_r == 2'h0) begin
         blink_cnt_r <= 12'h000;
         blink_r     <= 1'b0;
      end else if (f_tick_r) begin
         if (blink_cnt_r >= blink_half - 12'h001) begin
            blink_cnt_r <= 12'h000;
            blink_r     <= ~blink_r;
         end else begin
            blink_cnt_r <= blink_cnt_r + 12'h001;
         end
      end
   end

   // displayed row: phase, plus bank choice and blink swap
   assign swap_now = blink_r & blink_swap_r & has_alt(drive_mode_r);
   assign show_row = ((out_bank_r ^ swap_now) & has_alt(drive_mode_r))
                     ? bp_phase_r + `LDR_ALT_ROW
                     : bp_phase_r;

   genvar gi;
   generate
      for (gi = 0; gi < WORDS; gi++) begin : g_col
         assign seg_w[gi] = ram[gi][show_row];
      end
   endgenerate

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         seg_data_r <= '0;
         blank_r    <= 1'b1;
      end else if (f_tick_r) begin
         seg_data_r <= seg_w;
         blank_r    <= ~disp_en_r
                       | (blink_r & ~swap_now);
      end
   end
endmodule

// ---- hdl/ldr_params.svh ----
`ifndef LDR_PARAMS_SVH
`define LDR_PARAMS_SVH

// display RAM geometry
`define LDR_RAM_WORDS      80
`define LDR_LAST_WORD      7'h4F
`define LDR_PTR_W          7
`define LDR_ROWS           4
`define LDR_ALT_ROW        2'h2

// control byte fields
`define LDR_CTRL_MORE_BIT  7
`define LDR_CTRL_RS_BIT    6

// command opcodes: mask and match
`define LDR_OP_PTR_BIT     7
`define LDR_OP_MODE_MASK   8'hF0
`define LDR_OP_MODE        8'hC0
`define LDR_OP_DEV_MASK    8'hF8
`define LDR_OP_DEV         8'hE0
`define LDR_OP_BANK_MASK   8'hFC
`define LDR_OP_BANK        8'hF8
`define LDR_OP_BLINK_MASK  8'hF8
`define LDR_OP_BLINK       8'hF0

// command field positions
`define LDR_MODE_EN_BIT    3
`define LDR_MODE_BIAS_BIT  2
`define LDR_BANK_IN_BIT    1
`define LDR_BANK_OUT_BIT   0
`define LDR_BLINK_SWAP_BIT 2

// reset values
`define LDR_RST_MODE       2'b00
`define LDR_RST_BLINK      2'b00

// timing: core clock and logic clock rates, blink ratios of f_clk
`define LDR_CORE_HZ        200000000
`define LDR_FCLK_HZ        1970
`define LDR_FCLK_DIV       (`LDR_CORE_HZ / `LDR_FCLK_HZ)
`define LDR_FRAME_TICKS    24
`define LDR_BLINK_RATIO1   768
`define LDR_BLINK_RATIO2   1536
`define LDR_BLINK_RATIO3   3072

`endif

// ---- hdl/ldr_pkg.sv ----
package ldr_pkg;

   typedef enum logic [1:0] {
      LDR_MODE_QUAD = 2'b00,
      LDR_MODE_STAT = 2'b01,
      LDR_MODE_DUO  = 2'b10,
      LDR_MODE_TRI  = 2'b11
   } ldr_mode_t;

   // gray path: control byte -> body bytes -> bit-serial write
   typedef enum logic [1:0] {
      LDR_ST_CTRL  = 2'b00,
      LDR_ST_BODY  = 2'b01,
      LDR_ST_WRITE = 2'b11
   } ldr_state_t;

endpackage

// ---- hdl/ldr_buf2.sv ----
`timescale 1ns/1ps
module ldr_buf2 #(
   parameter int W = 9
) (
   // clock and reset
   input  wire logic         core_clk,
   input  wire logic         resetn,
   // filling side
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_data,
   output logic              in_ready,
   // draining side
   output logic              out_valid,
   output logic [W-1:0]      out_data,
   input  wire logic         out_ready
);
   localparam int DEPTH = 2;

   logic [W-1:0] mem [DEPTH];
   logic         wr_idx_r;
   logic         rd_idx_r;
   logic [1:0]   cnt_r;
   logic [1:0]   cnt_nxt;
   logic         push;
   logic         pop;

   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   assign out_valid = (cnt_r != 2'h0);
   assign out_data  = mem[rd_idx_r];

   always_comb begin
      cnt_nxt = cnt_r;
      if (push & ~pop) begin
         cnt_nxt = cnt_r + 2'h1;
      end else if (pop & ~push) begin
         cnt_nxt = cnt_r - 2'h1;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_r    <= 2'h0;
         in_ready <= 1'b0;
         wr_idx_r <= 1'b0;
         rd_idx_r <= 1'b0;
      end else begin
         cnt_r    <= cnt_nxt;
         in_ready <= (cnt_nxt != 2'h2);
         if (push) begin
            wr_idx_r <= ~wr_idx_r;
         end
         if (pop) begin
            rd_idx_r <= ~rd_idx_r;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (push) begin
         mem[wr_idx_r] <= in_data;
      end
   end
endmodule

// ---- bench/ldr_core_asserts.sv ----
`timescale 1ns/1ps
module ldr_core_asserts
   import ldr_pkg::*;
#(
   parameter int FCLK_DIV = 4,
   parameter int WORDS    = 80
) (
   // clock and reset
   input wire logic               core_clk,
   input wire logic               resetn,
   // byte stream and acknowledge
   input wire logic               in_valid,
   input wire logic               in_ready,
   input wire logic               ack_done,
   input wire logic               ack_slot,
   input wire logic               ack_output_pin,
   input wire logic               ack_oe_n_r,
   // display side
   input wire logic [1:0]         bp_phase_r,
   input wire logic               blank_r,
   input wire logic               bias_half_r,
   input wire ldr_pkg::ldr_mode_t drive_mode_r
);
   logic [7:0] since_ack_r;
   logic [7:0] mode_age_r;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn)
         since_ack_r <= 8'hFF;
      else if (ack_done)
         since_ack_r <= 8'h00;
      else if (since_ack_r != 8'hFF)
         since_ack_r <= since_ack_r + 8'h01;
   end

   // settled mode: old phase may linger up to one long phase
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn)
         mode_age_r <= 8'h00;
      else if ($changed(drive_mode_r))
         mode_age_r <= 8'h00;
      else if (mode_age_r != 8'hFF)
         mode_age_r <= mode_age_r + 8'h01;
   end

   AST_ACK_PIN_LOW: assert property (ack_output_pin == 1'b0)
      else $error("ack pin value not low");
   AST_ACK_ONLY_IN_SLOT: assert property (!ack_slot |=> ack_oe_n_r)
      else $error("ack pin pulled outside slot");
   AST_PHASE_ORDER: assert property ($changed(bp_phase_r) |->
      bp_phase_r == 2'h0 || bp_phase_r == $past(bp_phase_r) + 2'h1)
      else $error("phase out of order");
   AST_PHASE_HOLD: assert property (
      $changed(bp_phase_r) |=> $stable(bp_phase_r) [*3])
      else $error("phase too short");
   AST_PHASE_RANGE: assert property (
      mode_age_r == 8'hFF && drive_mode_r != LDR_MODE_QUAD
      |-> bp_phase_r < 2'(drive_mode_r))
      else $error("phase beyond row count");
   AST_CMD_WAITS_ACK: assert property (
      $changed(drive_mode_r) || $changed(bias_half_r) |-> since_ack_r < 8'd16)
      else $error("command applied without ack");
   AST_READY_AFTER_RESET: assert property ($rose(resetn)
      |-> !in_ready ##1 in_ready)
      else $error("ready not raised after reset");
   AST_READY_DROP: assert property ($fell(in_ready)
      |-> $past(in_valid) && $past(in_ready))
      else $error("ready fell without a take");

   cover property (in_valid && !in_ready);
   cover property (drive_mode_r == LDR_MODE_QUAD && bp_phase_r == 2'h3);
   cover property ($rose(blank_r));
endmodule

// ---- bench/ldr_front_model.sv ----
`timescale 1ns/1ps
module ldr_front_model (
   // clock
   input wire logic        core_clk,
   // byte stream
   output logic            in_valid,
   output logic [7:0]      in_byte,
   output logic            in_first,
   input wire logic        in_ready,
   // acknowledge timing
   output logic            ack_done,
   output logic            ack_slot,
   input wire logic        ack_oe_n_r
);
   logic ack_seen;

   initial begin
      in_valid = 1'b0;
      in_byte  = 8'h00;
      in_first = 1'b0;
      ack_done = 1'b0;
      ack_slot = 1'b0;
      ack_seen = 1'b1;
   end

   // new transfers only from idle; ack pin level is never waited on
   task automatic send(input logic f, input logic [7:0] b, input logic fast);
      @(negedge core_clk);
      in_valid = 1'b1;
      in_byte  = b;
      in_first = f;
      do @(posedge core_clk); while (!in_ready);
      if (!fast) begin
         @(negedge core_clk);
         in_valid = 1'b0;
         in_byte  = ~b;
         in_first = 1'b0;
         repeat (8) @(negedge core_clk);
         ack_seen = 1'b1;
         ack_slot = 1'b1;
         repeat (2) begin
            @(negedge core_clk);
            ack_seen = ack_seen & ack_oe_n_r;
         end
         ack_slot = 1'b0;
         ack_done = 1'b1;
         @(negedge core_clk);
         ack_done = 1'b0;
      end
   endtask
endmodule

// ---- bench/ldr_core_bench.sv ----
`timescale 1ns/1ps
bind ldr_core ldr_core_asserts #(.FCLK_DIV(FCLK_DIV), .WORDS(WORDS))
   ldr_core_asserts_i (
   .core_clk       (core_clk),
   .resetn         (resetn),
   .in_valid       (in_valid),
   .in_ready       (in_ready),
   .ack_done       (ack_done),
   .ack_slot       (ack_slot),
   .ack_output_pin (ack_output_pin),
   .ack_oe_n_r     (ack_oe_n_r),
   .bp_phase_r     (bp_phase_r),
   .blank_r        (blank_r),
   .bias_half_r    (bias_half_r),
   .drive_mode_r   (drive_mode_r)
);

module ldr_core_bench;
   import ldr_pkg::*;
   localparam int DIV = 4;
   logic              core_clk = 1'b0;
   logic              resetn   = 1'b0;
   logic              in_valid;
   logic [7:0]        in_byte;
   logic              in_first;
   logic              in_ready;
   logic              ack_done;
   logic              ack_slot;
   logic              ack_output_pin;
   logic              ack_oe_n_r;
   logic [79:0]       seg_data_r;
   logic [1:0]        bp_phase_r;
   logic              blank_r;
   logic              bias_half_r;
   ldr_mode_t         drive_mode_r;
   int                fails = 0;
   int                n_compared = 0;

   always #2.5 core_clk = ~core_clk;

   ldr_core #(.FCLK_DIV(DIV)) ldr_core_i (
      .core_clk        (core_clk),
      .resetn          (resetn),
      .in_valid        (in_valid),
      .in_byte         (in_byte),
      .in_first        (in_first),
      .in_ready        (in_ready),
      .ack_done        (ack_done),
      .ack_slot        (ack_slot),
      .ack_output_pin  (ack_output_pin),
      .ack_oe_n_r      (ack_oe_n_r),
      .hw_subaddr_bit0 (1'b0),
      .hw_subaddr_bit1 (1'b0),
      .hw_subaddr_bit2 (1'b0),
      .seg_data_r      (seg_data_r),
      .bp_phase_r      (bp_phase_r),
      .blank_r         (blank_r),
      .bias_half_r     (bias_half_r),
      .drive_mode_r    (drive_mode_r)
   );

   ldr_front_model ldr_front_model_i (
      .core_clk   (core_clk),
      .in_valid   (in_valid),
      .in_byte    (in_byte),
      .in_first   (in_first),
      .in_ready   (in_ready),
      .ack_done   (ack_done),
      .ack_slot   (ack_slot),
      .ack_oe_n_r (ack_oe_n_r)
   );

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // first byte is control; fast bursts skip ack timing to fill the buffer;
   // leading control and command bytes and the last byte still wait for their own ack
   task automatic xfer(input logic [7:0] q[$], input logic fast);
      foreach (q[i])
         ldr_front_model_i.send(i == 0, q[i],
                                fast && i > 1 && i < q.size() - 1);
      repeat (40) @(posedge core_clk);
   endtask

   task automatic cmd(input logic [7:0] c);
      xfer('{8'h00, c}, 1'b0);
   endtask

   task automatic wait_blank(output int n);
      logic b;
      b = blank_r;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (blank_r === b && n < 20000);
   endtask

   // sync to the start of phase k, then let one tick load the segments
   task automatic wait_phase(input int k);
      int n;
      n = 0;
      while (bp_phase_r === 2'(k) && n < 500) begin
         @(posedge core_clk);
         n++;
      end
      while (bp_phase_r !== 2'(k) && n < 500) begin
         @(posedge core_clk);
         n++;
      end
      repeat (DIV + 3) @(posedge core_clk);
   endtask

   function automatic logic [7:0] rv(input logic [7:0] b);
      for (int i = 0; i < 8; i++)
         rv[i] = b[7-i];
   endfunction

   initial begin
      #400000;
      fails++;
      stop_test();
   end

   initial begin
      int         n;
      logic [7:0] b;
      b = 8'hA5;
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      resetn = 1'b1;
      repeat (2) @(posedge core_clk);
      for (int m = 0; m < 4; m++) begin
         cmd(8'hC8 | 8'(m));
         chk(32'(drive_mode_r), 32'(m));
      end
      chk(ldr_front_model_i.ack_seen, 0);
      cmd(8'hC9);
      xfer('{8'h80, 8'h00, 8'h40, 8'h12, 8'h6B, 8'hFF, 8'h00}, 1'b1);
      chk(seg_data_r[31:0], {rv(8'h00), rv(8'hFF), rv(8'h6B), rv(8'h12)});
      xfer('{8'h80, 8'h10, 8'h80, 8'hE1, 8'hC0, 8'hAA, 8'h80, 8'hE0,
             8'h40, 8'h55}, 1'b0);
      chk(seg_data_r[31:16], {rv(8'h55), 8'hFF});
      xfer('{8'h80, 8'h4C, 8'h80, 8'hE7, 8'h40, 8'h0F}, 1'b0);
      chk(seg_data_r[7:0], {rv(8'h12) >> 4, 4'hF});
      cmd(8'hFA);
      xfer('{8'h80, 8'h00, 8'h40, 8'h81}, 1'b0);
      chk(seg_data_r[7:0], 8'h4F);
      cmd(8'hF9);
      chk(seg_data_r[7:0], rv(8'h81));
      cmd(8'hF8);
      for (int r = 1; r < 4; r++) begin
         cmd(8'hF0 | 8'(r));
         wait_blank(n);
         wait_blank(n);
         chk(n, (768 << (r - 1)) / 2 * DIV);
      end
      cmd(8'hF0);
      cmd(8'hF5);
      n = 0;
      while (seg_data_r[7:0] !== 8'h81 && n < 3000) begin
         @(posedge core_clk);
         n++;
      end
      chk(seg_data_r[7:0], 8'h81);
      cmd(8'hF0);
      cmd(8'hC5);
      chk(blank_r, 1'b1);
      chk(bias_half_r, 1'b1);
      cmd(8'hC8);
      chk(blank_r, 1'b0);
      chk(bias_half_r, 1'b0);
      xfer('{8'h80, 8'h28, 8'h40, b}, 1'b0);
      for (int k = 0; k < 4; k++) begin
         wait_phase(k);
         chk(seg_data_r[41:40], {b[3-k], b[7-k]});
      end
      cmd(8'hCB);
      xfer('{8'h80, 8'h30, 8'h40, b}, 1'b0);
      for (int k = 0; k < 2; k++) begin
         wait_phase(k);
         chk(seg_data_r[50:48], {b[1-k], b[4-k], b[7-k]});
      end
      wait_phase(2);
      chk(seg_data_r[49:48], {b[2], b[5]});
      cmd(8'hCA);
      xfer('{8'h80, 8'h38, 8'h40, b}, 1'b0);
      for (int k = 0; k < 2; k++) begin
         wait_phase(k);
         chk(seg_data_r[59:56], {b[1-k], b[3-k], b[5-k], b[7-k]});
      end
      stop_test();
   end
endmodule
